// ---- common/swd_pkg.sv ----
// constants and types of the system watchdog timer
package swd_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned SWD_CNT_W = 16;
  localparam int unsigned SWD_PRE_W = 14;

  // prescaler terminal counts (ratio minus one)
  localparam logic [13:0] SWD_PRE_MAX_SLOW = 14'h3fff; // 16384
  localparam logic [13:0] SWD_PRE_MAX_FAST = 14'h00ff; // 256

  // ------------------------------------------------------------
  // power-up interval: 6.5 ms at a 10 MHz system clock
  // ------------------------------------------------------------
  localparam int unsigned SWD_DEF_INTERVAL_US = 6500;
  localparam int unsigned SWD_DEF_FSYS_KHZ    = 10000;
  // prescaled ticks needed, rounded up to whole ticks
  localparam int unsigned SWD_DEF_TICKS =
    (SWD_DEF_INTERVAL_US * SWD_DEF_FSYS_KHZ / 1000 + 16383) / 16384;
  localparam logic [15:0] SWD_RELOAD_RST =
    16'(32'h0001_0000 - SWD_DEF_TICKS);
  localparam logic        SWD_SLOW_RST   = 1'b1;

  // cycles from prewarning to reset request
  localparam logic [7:0]  SWD_RST_DELAY_CYC = 8'h40;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [4:0] SWD_OFF_CTRL   = 5'h00;
  localparam logic [4:0] SWD_OFF_CMD    = 5'h04;
  localparam logic [4:0] SWD_OFF_RELOAD = 5'h08;
  localparam logic [4:0] SWD_OFF_COUNT  = 5'h0c;
  localparam logic [4:0] SWD_OFF_STATUS = 5'h10;
  localparam logic [4:0] SWD_OFF_MASK   = 5'h14;

  // field positions
  localparam int unsigned SWD_CTRL_SLOW = 0;
  localparam int unsigned SWD_CMD_SVC   = 0;
  localparam int unsigned SWD_CMD_DIS   = 1;
  localparam int unsigned SWD_CMD_ENA   = 2;
  localparam int unsigned SWD_CNT_EN    = 16;
  localparam int unsigned SWD_CNT_PEND  = 17;
  localparam int unsigned SWD_ST_WARN   = 0;
  localparam int unsigned SWD_ST_RST    = 1;

  // interrupt mask after reset: prewarning enabled
  localparam logic [1:0] SWD_MASK_RST = 2'h1;

  // supervision phases
  typedef enum logic [1:0] {
    SWD_RUN,
    SWD_WARN,
    SWD_RESET
  } swd_state_t;

endpackage

// ---- hw/swd_prescaler.sv ----
// prescaler that divides the system clock by 16384 or 256
`timescale 1ns/1ps
module swd_prescaler (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clkEn,
  // control
  input  wire logic run,
  input  wire logic clear,
  input  wire logic slowSel,
  // one-cycle tick at the divided rate
  output logic      tick
);

  // ------------------------------------------------------------
  // divider state
  // ------------------------------------------------------------
  logic [13:0] preCnt_q;  // running count
  logic [13:0] preCnt_d;  // next count
  wire  [13:0] preMax;    // terminal count of selected ratio

  // ratio switch takes effect at once; a count at or past the new terminal ticks at once
  assign preMax = slowSel ? swd_pkg::SWD_PRE_MAX_SLOW
                          : swd_pkg::SWD_PRE_MAX_FAST;

  // tick on terminal count while running
  assign tick = run & (preCnt_q >= preMax);

  // clear wins over counting
  assign preCnt_d = clear ? 14'h0000 :
                    tick  ? 14'h0000 :
                    run   ? preCnt_q + 14'h0001 : preCnt_q;

  // counter flop, frozen while the enable is low
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      preCnt_q <= 14'h0000;
    end else if (clkEn) begin
      preCnt_q <= preCnt_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_prescale_wrap: assert property (
    clkEn && tick && !clear |=> preCnt_q == 14'h0000
  ) else $error("prescaler did not wrap after tick");

  a_prescale_clear: assert property (
    clkEn && clear |=> preCnt_q == 14'h0000 && !tick
  ) else $error("prescaler not cleared by service");

endmodule

// ---- hw/swd_top.sv ----
// system watchdog timer with avalon-mm register slave
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module swd_top (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // system side
  output logic             irq,
  output logic             resetRequest
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  swd_pkg::swd_state_t state_q;   // supervision phase
  swd_pkg::swd_state_t state_d;
  logic [15:0] count_q;           // watchdog counter
  logic [15:0] count_d;
  logic [7:0]  delay_q;           // prewarning to reset delay
  logic [7:0]  delay_d;
  logic        enabled_q;         // supervision on
  logic        slowSel_q;         // 1 selects /16384
  logic [15:0] reload_q;          // supervision reload value
  logic [1:0]  status_q;          // sticky events
  logic [1:0]  mask_q;            // interrupt mask
  logic        waitReq_q;         // bus wait, low one cycle
  logic [31:0] rdData_q;          // captured read data
  logic        irq_q;
  logic        rstReq_q;
  logic        warnEv;            // overflow this cycle
  logic        rstEv;             // reset request this cycle

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // a request completes in the cycle waitrequest is low
  wire       busReq  = avs_read | avs_write;
  wire       wrDone  = avs_write & ~waitReq_q;
  wire [2:0] wordIdx = avs_address[4:2];

  // register selects
  wire selCtrl = wordIdx == swd_pkg::SWD_OFF_CTRL[4:2];
  wire selCmd  = wordIdx == swd_pkg::SWD_OFF_CMD[4:2];
  wire selRel  = wordIdx == swd_pkg::SWD_OFF_RELOAD[4:2];
  wire selCnt  = wordIdx == swd_pkg::SWD_OFF_COUNT[4:2];
  wire selStat = wordIdx == swd_pkg::SWD_OFF_STATUS[4:2];
  wire selMask = wordIdx == swd_pkg::SWD_OFF_MASK[4:2];

  // write strobes per register
  wire wrCtrl = wrDone & selCtrl;
  wire wrCmd  = wrDone & selCmd;
  wire wrRel  = wrDone & selRel;
  wire wrStat = wrDone & selStat;
  wire wrMask = wrDone & selMask;

  // ------------------------------------------------------------
  // commands
  // ------------------------------------------------------------
  // service, disable instruction, enable instruction
  wire svcCmd = wrCmd & avs_writedata[swd_pkg::SWD_CMD_SVC];
  wire disCmd = wrCmd & avs_writedata[swd_pkg::SWD_CMD_DIS];
  wire enaCmd = wrCmd & avs_writedata[swd_pkg::SWD_CMD_ENA];

  // enable wins when both commands come in one write
  wire enabled_d = enaCmd ? 1'b1 :
                   disCmd ? 1'b0 : enabled_q;

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  // counting only while on and not yet overflowed
  wire running = enabled_q & (state_q == swd_pkg::SWD_RUN);
  // service in the run phase restarts the divider
  wire svcRun  = svcCmd & (state_q == swd_pkg::SWD_RUN);
  wire tick;

  swd_prescaler u_pre (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .clkEn   (clkEn),
    .run     (running),
    .clear   (svcRun),
    .slowSel (slowSel_q),
    .tick    (tick)
  );

  // wrap from all ones is the overflow
  wire ovf = running & tick & (count_q == 16'hffff);

  // ------------------------------------------------------------
  // supervision sequence
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    delay_d = delay_q;
    warnEv  = 1'b0;
    rstEv   = 1'b0;
    unique case (state_q)
      swd_pkg::SWD_RUN: begin
        if (svcRun) begin
          // service reloads, never zero
          count_d = reload_q;
        end else if (ovf) begin
          // prewarning first
          count_d = reload_q;
          state_d = swd_pkg::SWD_WARN;
          delay_d = 8'h00;
          warnEv  = 1'b1;
        end else if (running && tick) begin
          count_d = count_q + 16'h0001;
        end
      end
      swd_pkg::SWD_WARN: begin
        // service here is ignored on purpose
        if (delay_q == swd_pkg::SWD_RST_DELAY_CYC - 8'h01) begin
          state_d = swd_pkg::SWD_RESET;
          rstEv   = 1'b1;
        end else begin
          delay_d = delay_q + 8'h01;
        end
      end
      swd_pkg::SWD_RESET: begin
        // held until the system reset arrives
        state_d = swd_pkg::SWD_RESET;
      end
    endcase
  end

  // ------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------
  // write one to clear; a same-cycle event wins
  wire [1:0] evVec    = {rstEv, warnEv};
  wire [1:0] w1cVec   = wrStat ? avs_writedata[1:0] : 2'b00;
  wire [1:0] status_d = (status_q & ~w1cVec) | evVec;
  wire [1:0] mask_d   = wrMask ? avs_writedata[1:0] : mask_q;
  // level interrupt follows next status and mask
  wire       irq_d    = |(status_d & mask_d);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [31:0] ctrlRd = {31'h0, slowSel_q};
  wire [31:0] relRd  = {16'h0, reload_q};
  wire [31:0] cntRd  = {14'h0, rstReq_q, enabled_q, count_q};
  wire [31:0] statRd = {30'h0, status_q};
  wire [31:0] maskRd = {30'h0, mask_q};
  // unmapped words and command read as zero
  wire [31:0] rdMux  = selCtrl ? ctrlRd :
                       selRel  ? relRd  :
                       selCnt  ? cntRd  :
                       selStat ? statRd :
                       selMask ? maskRd : 32'h0000_0000;

  // ------------------------------------------------------------
  // bus handshake flops
  // ------------------------------------------------------------
  // one wait cycle per access keeps the mux off the bus
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      waitReq_q <= 1'b1;
      rdData_q  <= 32'h0000_0000;
    end else if (clkEn) begin
      waitReq_q <= ~(busReq & waitReq_q);
      if (avs_read && waitReq_q) begin
        rdData_q <= rdMux;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration flops
  // ------------------------------------------------------------
  // reset leaves the watchdog armed with default interval
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      enabled_q <= 1'b1;
      slowSel_q <= swd_pkg::SWD_SLOW_RST;
      reload_q  <= swd_pkg::SWD_RELOAD_RST;
      mask_q    <= swd_pkg::SWD_MASK_RST;
    end else if (clkEn) begin
      enabled_q <= enabled_d;
      mask_q    <= mask_d;
      if (wrCtrl) begin
        slowSel_q <= avs_writedata[swd_pkg::SWD_CTRL_SLOW];
      end
      if (wrRel) begin
        reload_q <= avs_writedata[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // counter and sequence flops
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= swd_pkg::SWD_RUN;
      count_q <= swd_pkg::SWD_RELOAD_RST;
      delay_q <= 8'h00;
    end else if (clkEn) begin
      state_q <= state_d;
      count_q <= count_d;
      delay_q <= delay_d;
    end
  end

  // ------------------------------------------------------------
  // event and output flops
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      status_q <= 2'b00;
      irq_q    <= 1'b0;
      rstReq_q <= 1'b0;
    end else if (clkEn) begin
      status_q <= status_d;
      irq_q    <= irq_d;
      rstReq_q <= rstReq_q | rstEv;
    end
  end

  // outputs come straight from flops
  assign avs_readdata    = rdData_q;
  assign avs_waitrequest = waitReq_q;
  assign irq             = irq_q;
  assign resetRequest    = rstReq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_reset_armed: assert property (
    !$past(resetn) |-> enabled_q && state_q == swd_pkg::SWD_RUN
  ) else $error("watchdog not armed after reset");

  a_default_interval: assert property (
    !$past(resetn) |->
      reload_q == 16'hfffc && slowSel_q && count_q == 16'hfffc
  ) else $error("default interval setup wrong");

  a_disable_cmd: assert property (
    clkEn && disCmd && !enaCmd |=> !enabled_q ##1 $stable(count_q)
  ) else $error("disable command not honoured");

  a_enable_cmd: assert property (
    clkEn && enaCmd |=> enabled_q
  ) else $error("enable command not honoured");

  a_count_step: assert property (
    clkEn && running && tick && !svcRun && count_q != 16'hffff
      |=> count_q == $past(count_q) + 16'h0001
  ) else $error("counter did not advance by one");

  a_overflow_warn: assert property (
    clkEn && ovf && !svcRun |=>
      state_q == swd_pkg::SWD_WARN && status_q[0] &&
      count_q == $past(reload_q) && !rstReq_q
  ) else $error("overflow did not raise prewarning");

  a_hold_disabled: assert property (
    clkEn && !enabled_q && !svcCmd && state_q == swd_pkg::SWD_RUN
      |=> $stable(count_q) && !status_q[0] || $past(status_q[0])
  ) else $error("disabled watchdog changed state");

  a_service_reload: assert property (
    clkEn && svcRun |=> count_q == $past(reload_q)
  ) else $error("service did not reload counter");

  a_warn_first: assert property (
    $rose(rstReq_q) |-> $past(state_q) == swd_pkg::SWD_WARN
  ) else $error("reset request without prewarning");

  a_reset_delay: assert property (
    $rose(rstReq_q) |-> $past(delay_q) == 8'h3f
  ) else $error("reset request delay wrong");

  a_no_cancel: assert property (
    state_q == swd_pkg::SWD_WARN |=> state_q != swd_pkg::SWD_RUN
  ) else $error("pending reset was cancelled");

  c_service: cover property (clkEn && svcRun);
  c_overflow: cover property (clkEn && ovf);
  c_reset_req: cover property ($rose(rstReq_q));
  c_disable: cover property (clkEn && disCmd && !enaCmd);

endmodule

// ---- sim/swd_sys_model.sv ----
// model of the system reset and interrupt logic beside the watchdog
`timescale 1ns/1ps
module swd_sys_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // requests from the watchdog
  input  wire logic irq,
  input  wire logic resetRequest,
  // cycle stamps seen by the system side
  output int        cyc,
  output int        warnAt,
  output int        rstAt
);
  logic irqPrev;  // interrupt at the previous edge
  logic rstPrev;  // reset request at the previous edge

  // ------------------------------------------------------------
  // stamp the cycle at which each request rises
  // ------------------------------------------------------------
  // free-running stamp, kept through reset so delays stay measurable
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    // edge history restarts with every system reset
    irqPrev <= irq & resetn;
    rstPrev <= resetRequest & resetn;
    if (irq === 1'b1 && irqPrev !== 1'b1) begin
      warnAt <= cyc;
    end
    if (resetRequest === 1'b1 && rstPrev !== 1'b1) begin
      rstAt <= cyc;
    end
  end
endmodule

// ---- sim/system_watchdog_timer_tb_top.sv ----
// self-checking testbench of the system watchdog timer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin \
  errors++; $display("unexpected %s expected %h seen %h", nm, exp, got); \
  end end
module system_watchdog_timer_tb_top;
  logic        ref_clk;         // 125 MHz system clock
  logic        resetn;          // synchronous reset, active low
  logic        clkEn;           // clock enable
  logic [4:0]  avsAddress;      // bus address
  logic        avsRead;         // bus read
  logic        avsWrite;        // bus write
  logic [31:0] avsWritedata;    // bus write data
  logic [31:0] avsReaddata;     // bus read data
  logic        avsWaitrequest;  // bus stall
  logic        irq;             // prewarning and reset interrupt
  logic        resetRequest;    // reset request to system
  int          cyc;             // stamps from the system model
  int          warnAt;
  int          rstAt;
  int          errors;          // mismatches
  int          testsRun;        // comparisons
  int          tick;            // timeout counter
  int          t0;              // start stamp of an interval
  int          rldM;            // model reload value
  int          rstRld;          // model reset reload value
  logic [15:0] lfsr;            // random source
  logic [31:0] rd;              // last read word
  logic [4:0]  offs[6];         // reset check table
  logic [31:0] expv[$];         // model queue of reset values

  // ------------------------------------------------------------
  // design and system side
  // ------------------------------------------------------------
  swd_top dut_u (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .irq(irq),
    .resetRequest(resetRequest));
  swd_sys_model sys_u (.ref_clk(ref_clk), .resetn(resetn), .irq(irq),
    .resetRequest(resetRequest), .cyc(cyc), .warnAt(warnAt),
    .rstAt(rstAt));

  // ------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // a hang counts as a mismatch; the run needs well under 12000 cycles
  always @(posedge ref_clk) begin
    tick++;
    if (tick == 20000) begin
      errors++;
      complete_run();
    end
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // one bus cycle; request held until waitrequest is sampled low
  task automatic bus_rw(input logic wr, input logic [4:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    // only the bench timeout ends a stalled wait
    do begin
      @(posedge ref_clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_rw(1'b1, a, d, q);
  endtask
  task automatic rd_reg(input logic [4:0] a);
    bus_rw(1'b0, a, 32'h0000_0000, rd);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {resetn, avsRead, avsWrite} = 3'h0;
    clkEn = 1'b1;
    avsAddress = 5'h00;
    avsWritedata = 32'h0000_0000;
    lfsr = 16'h0004;
    // 6.5 ms at 10 MHz in whole ticks of 16384 cycles
    rstRld = 65536 - (6500 * 10 + 16383) / 16384;
    offs = '{swd_pkg::SWD_OFF_COUNT, swd_pkg::SWD_OFF_CTRL,
      swd_pkg::SWD_OFF_MASK, swd_pkg::SWD_OFF_STATUS,
      swd_pkg::SWD_OFF_CMD, 5'h18};
    for (int pass = 0; pass < 2; pass++) begin
      resetn <= 1'b0;
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      `CHK("resetRequest", 1'b0, resetRequest)
      expv = {32'h0001_0000 | rstRld, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 6; i++) begin
        rd_reg(offs[i]);
        `CHK("reset value", expv[i], rd)
      end
      if (pass == 1) begin
        complete_run();
      end
      // random reloads, ratio bit from the lfsr (slow on the sixth pass); service clears the prescaler
      for (int i = 0; i < 6; i++) begin
        lfsr = lfsr_next(lfsr);
        rldM = 32'hff00 | lfsr[7:0];
        wr_reg(swd_pkg::SWD_OFF_CTRL, {31'h0, lfsr[8]});
        rd_reg(swd_pkg::SWD_OFF_CTRL);
        `CHK("ctrl", {31'h0, lfsr[8]}, rd)
        wr_reg(swd_pkg::SWD_OFF_RELOAD, rldM);
        wr_reg(swd_pkg::SWD_OFF_CMD, 32'h1);
        rd_reg(swd_pkg::SWD_OFF_COUNT);
        `CHK("reloaded", 32'h0001_0000 | rldM, rd)
      end
      // counting rate at ratio 256
      wr_reg(swd_pkg::SWD_OFF_CTRL, 32'h0);
      wr_reg(swd_pkg::SWD_OFF_RELOAD, 32'hfff0);
      wr_reg(swd_pkg::SWD_OFF_CMD, 32'h1);
      // clock enable low must freeze divider and counter
      clkEn <= 1'b0;
      repeat (300) @(posedge ref_clk);
      clkEn <= 1'b1;
      repeat (868) @(posedge ref_clk);
      rd_reg(swd_pkg::SWD_OFF_COUNT);
      `CHK("count rate", 32'h0001_fff3, rd)
      // service then disable back to back: count must freeze
      wr_reg(swd_pkg::SWD_OFF_CMD, 32'h1);
      wr_reg(swd_pkg::SWD_OFF_CMD, 32'h2);
      repeat (700) @(posedge ref_clk);
      rd_reg(swd_pkg::SWD_OFF_COUNT);
      `CHK("disabled hold", 32'h0000_fff0, rd)
      `CHK("irq off", 1'b0, irq)
      wr_reg(swd_pkg::SWD_OFF_CMD, 32'h6);
      rd_reg(swd_pkg::SWD_OFF_COUNT);
      `CHK("enabled again", 32'h0001_fff0, rd)
      // regular service keeps the requests away
      wr_reg(swd_pkg::SWD_OFF_RELOAD, 32'hfffe);
      for (int i = 0; i < 6; i++) begin
        wr_reg(swd_pkg::SWD_OFF_CMD, 32'h1);
        repeat (400) @(posedge ref_clk);
        `CHK("no warning", 2'b00, {irq, resetRequest})
      end
      // missed service: two ticks of 256 to prewarning, then reset
      wr_reg(swd_pkg::SWD_OFF_CMD, 32'h1);
      t0 = cyc;
      // look inside the 64-cycle gap between prewarning and reset
      repeat (540) @(posedge ref_clk);
      `CHK("warn time", 1, (warnAt - t0 >= 510 && warnAt - t0 <= 516))
      `CHK("warn first", 1'b0, resetRequest)
      wr_reg(swd_pkg::SWD_OFF_CMD, 32'h1);
      repeat (80) @(posedge ref_clk);
      `CHK("reset req", 1'b1, resetRequest)
      `CHK("delay", 1, (rstAt - warnAt >= 62 && rstAt - warnAt <= 66))
      rd_reg(swd_pkg::SWD_OFF_STATUS);
      `CHK("status", 32'h3, rd)
      // mask, then clear each sticky bit by writing ones
      wr_reg(swd_pkg::SWD_OFF_MASK, 32'h0);
      repeat (2) @(posedge ref_clk);
      `CHK("masked irq", 1'b0, irq)
      wr_reg(swd_pkg::SWD_OFF_MASK, 32'h3);
      wr_reg(swd_pkg::SWD_OFF_STATUS, 32'h1);
      repeat (2) @(posedge ref_clk);
      `CHK("irq bit1", 1'b1, irq)
      wr_reg(swd_pkg::SWD_OFF_STATUS, 32'h2);
      repeat (2) @(posedge ref_clk);
      `CHK("irq cleared", 1'b0, irq)
      `CHK("sticky reset", 1'b1, resetRequest)
    end
  end
endmodule
